// ### pkg/esb_pkg.sv
// Package of constants for the E1 receive sync status bank
//
// Function
// (R1) Page-3 status registers sit at five-bit addresses 10H to 1FH, with 1AH and 1CH-1EH unused.
// (R2) Sync status bit 7 is one while basic frame alignment is lost and zero once acquired.
// (R3) Sync status bit 6 is one while multiframe alignment is lost and zero once acquired.
// (R4) Sync status bit 5 is one while CRC-4 multiframe alignment is lost and zero once acquired.
// (R5) Sync status bit 4 holds the first E bit of the most recent multiframe.
// (R6) Sync status bit 3 holds the second E bit of the most recent multiframe.
// (R7) Sync status bit 2 sets when CRC-4 multiframe sync is not found within 8 ms of basic sync.
// (R8) That timeout forces a new frame search only with maintenance on and auto interworking off.
// (R9) Sync status bit 1 rises once basic frame alignment has been lost for at least 100 ms.
// (R10) The prolonged-loss bit falls as soon as basic frame alignment is acquired again.
// (R11) Sync status bit 0 is one for CRC-to-CRC interworking and zero for a non-CRC far end.
// (R12) Reads change no state and writes to these addresses have no effect.
package esb_pkg;
    // ----------------------------------------
    // Register addresses on page 3
    // ----------------------------------------
    localparam logic [4:0] ADDR_FRAME_SYNC_STATUS = 5'h10;
    localparam logic [4:0] ADDR_ALARM_STATUS_FIRST = 5'h11;
    localparam logic [4:0] ADDR_TIMER_STATUS = 5'h12;
    localparam logic [4:0] ADDR_PHASE_STATUS_HIGH = 5'h13;
    localparam logic [4:0] ADDR_PHASE_STATUS_LOW = 5'h14;
    localparam logic [4:0] ADDR_RX_ALIGN_SIGNAL = 5'h15;
    localparam logic [4:0] ADDR_RX_LINE_SIGNAL_STATUS = 5'h16;
    localparam logic [4:0] ADDR_JITTER_BUFFER_STATUS = 5'h17;
    localparam logic [4:0] ADDR_RX_NONALIGN_SIGNAL = 5'h18;
    localparam logic [4:0] ADDR_RX_MULTIFRAME_SIGNAL = 5'h19;
    localparam logic [4:0] ADDR_ALARM_STATUS_SECOND = 5'h1b;
    localparam logic [4:0] ADDR_PART_IDENTIFIER = 5'h1f;
    localparam logic [1:0] PAGE_STATUS = 2'h3;
    // ----------------------------------------
    // Sync status field positions
    // ----------------------------------------
    localparam int BIT_FRAME_LOSS = 7;
    localparam int BIT_MULTIFRAME_LOSS = 6;
    localparam int BIT_CRC4_LOSS = 5;
    localparam int BIT_EBIT_FIRST = 4;
    localparam int BIT_EBIT_SECOND = 3;
    localparam int BIT_CRC4_TIMEOUT = 2;
    localparam int BIT_PROLONGED_LOSS = 1;
    localparam int BIT_INTERWORK = 0;
    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] UNUSED_READ = 8'h00;
    localparam longint CLK_HZ = 200000000;
    localparam longint CRC4_SEARCH_MS = 8;
    localparam longint PROLONGED_LOSS_MS = 100;
    localparam longint CRC4_SEARCH_CYCLES = (CRC4_SEARCH_MS * CLK_HZ) / 1000;
    localparam longint PROLONGED_LOSS_CYCLES = (PROLONGED_LOSS_MS * CLK_HZ + 999) / 1000;
    // Bus access state machine
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACTIVE = 2'b01
    } esb_bus_state_t;
endpackage

// ### rtl/esb_status_bank.sv
// E1 receive synchronization status register bank (page 3)
`timescale 1ns/1ps
`default_nettype none
module esb_status_bank
    import esb_pkg::*;
#(
    parameter int unsigned CRC4_SEARCH_LIMIT = 32'(CRC4_SEARCH_CYCLES),
    parameter int unsigned PROLONGED_LOSS_LIMIT = 32'(PROLONGED_LOSS_CYCLES),
    parameter logic [7:0] PART_ID = 8'h5a // Arbitrary value
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Parallel microprocessor port
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [4:0] addr,
    input wire logic [1:0] page,
    output logic [7:0] rd_data,
    output logic rd_data_oe_n,
    // Framer alignment state
    input wire logic frame_loss,
    input wire logic multiframe_loss,
    input wire logic crc4_multiframe_loss,
    input wire logic ebit_strobe,
    input wire logic rx_ebit_first,
    input wire logic rx_ebit_second,
    input wire logic crc4_interwork_state,
    input wire logic maintenance_enable,
    input wire logic auto_interwork_enable,
    // Other page-3 status words
    input wire logic [7:0] alarm_status_first,
    input wire logic [7:0] timer_status,
    input wire logic [7:0] phase_status_high,
    input wire logic [7:0] phase_status_low,
    input wire logic [7:0] rx_align_signal,
    input wire logic [7:0] rx_line_signal_status,
    input wire logic [7:0] jitter_buffer_status,
    input wire logic [7:0] rx_nonalign_signal,
    input wire logic [7:0] rx_multiframe_signal,
    input wire logic [7:0] alarm_status_second,
    // Control back to the framer
    output logic frame_search_force
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] bus_meta;
    logic [2:0] bus_sync;
    logic [1:0] ctl_meta;
    logic [1:0] ctl_sync;
    logic [4:0] addr_meta;
    logic [4:0] addr_sync;
    logic [1:0] page_meta;
    logic [1:0] page_sync;

    // Two flops on the host strobes; idle is all high
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            bus_meta <= 3'h7;
            bus_sync <= 3'h7;
        end
        else
        begin
            bus_meta <= {cs_n, rd_n, wr_n};
            bus_sync <= bus_meta;
        end
    end

    // Two flops on the address and page pins, sampled beside the strobes
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            addr_meta <= 5'h00;
            addr_sync <= 5'h00;
            page_meta <= 2'h0;
            page_sync <= 2'h0;
        end
        else
        begin
            addr_meta <= addr;
            addr_sync <= addr_meta;
            page_meta <= page;
            page_sync <= page_meta;
        end
    end

    // Two flops on the maintenance and interworking option levels
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ctl_meta <= 2'h0;
            ctl_sync <= 2'h0;
        end
        else
        begin
            ctl_meta <= {maintenance_enable, auto_interwork_enable};
            ctl_sync <= ctl_meta;
        end
    end

    logic host_read;
    logic reframe_allowed;

    // A read needs chip select and read strobe low with no write strobe
    assign host_read = !bus_sync[2] && !bus_sync[1] && bus_sync[0];
    // Reframe only with maintenance on and automatic interworking off
    assign reframe_allowed = ctl_sync[1] && !ctl_sync[0]; // [R8]

    // ----------------------------------------
    // Host read cycle
    // ----------------------------------------
    esb_bus_state_t bus_state;

    // Data drive waits one extra cycle so the synchronised address has settled
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            bus_state <= BUS_IDLE;
        end
        else
        begin
            case (bus_state)
                BUS_IDLE:
                begin
                    if (host_read)
                    begin
                        bus_state <= BUS_ACTIVE;
                    end
                end
                BUS_ACTIVE:
                begin
                    if (!host_read)
                    begin
                        bus_state <= BUS_IDLE;
                    end
                end
                default:
                begin
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Alignment timers
    // ----------------------------------------
    logic [31:0] search_count;
    logic [31:0] loss_count;
    logic crc4_search_timeout;
    logic prolonged_frame_loss_alarm;
    logic timeout_q;

    // 8 ms CRC-4 search window opened by basic frame sync
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            search_count <= 32'h0;
            crc4_search_timeout <= 1'b0;
        end
        else if (frame_loss || !crc4_multiframe_loss)
        begin
            search_count <= 32'h0; // [R7]
            crc4_search_timeout <= 1'b0;
        end
        else if (search_count >= CRC4_SEARCH_LIMIT - 1)
        begin
            crc4_search_timeout <= 1'b1; // [R7]
        end
        else
        begin
            search_count <= search_count + 32'h1;
        end
    end

    // 100 ms continuous loss detector, cleared on reacquisition
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            loss_count <= 32'h0;
            prolonged_frame_loss_alarm <= 1'b0;
        end
        else if (!frame_loss)
        begin
            loss_count <= 32'h0;
            prolonged_frame_loss_alarm <= 1'b0; // [R10]
        end
        else if (loss_count >= PROLONGED_LOSS_LIMIT - 1)
        begin
            prolonged_frame_loss_alarm <= 1'b1; // [R9]
        end
        else
        begin
            loss_count <= loss_count + 32'h1;
        end
    end

    // Reframe pulse on the rising edge of the timeout, options permitting
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            timeout_q <= 1'b0;
            frame_search_force <= 1'b0;
        end
        else
        begin
            timeout_q <= crc4_search_timeout;
            frame_search_force <= crc4_search_timeout && !timeout_q && reframe_allowed; // [R8]
        end
    end

    // ----------------------------------------
    // Synchronization status word
    // ----------------------------------------
    logic [7:0] frame_sync_status;
    logic ebit_first_q;
    logic ebit_second_q;

    // E bits latched once per multiframe
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ebit_first_q <= 1'b0;
            ebit_second_q <= 1'b0;
        end
        else if (ebit_strobe)
        begin
            ebit_first_q <= rx_ebit_first; // [R5]
            ebit_second_q <= rx_ebit_second; // [R6]
        end
    end

    // Status word assembly
    always_comb
    begin
        frame_sync_status = RESET_BYTE;
        frame_sync_status[BIT_FRAME_LOSS] = frame_loss; // [R2]
        frame_sync_status[BIT_MULTIFRAME_LOSS] = multiframe_loss; // [R3]
        frame_sync_status[BIT_CRC4_LOSS] = crc4_multiframe_loss; // [R4]
        frame_sync_status[BIT_EBIT_FIRST] = ebit_first_q; // [R5]
        frame_sync_status[BIT_EBIT_SECOND] = ebit_second_q; // [R6]
        frame_sync_status[BIT_CRC4_TIMEOUT] = crc4_search_timeout; // [R7]
        frame_sync_status[BIT_PROLONGED_LOSS] = prolonged_frame_loss_alarm; // [R9]
        frame_sync_status[BIT_INTERWORK] = crc4_interwork_state; // [R11]
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    logic [7:0] next_rd_data;

    // Address decode; no write path exists
    always_comb
    begin
        next_rd_data = UNUSED_READ;
        if (page_sync == PAGE_STATUS)
        begin
            case (addr_sync)
                ADDR_FRAME_SYNC_STATUS: next_rd_data = frame_sync_status; // [R1]
                ADDR_ALARM_STATUS_FIRST: next_rd_data = alarm_status_first;
                ADDR_TIMER_STATUS: next_rd_data = timer_status;
                ADDR_PHASE_STATUS_HIGH: next_rd_data = phase_status_high;
                ADDR_PHASE_STATUS_LOW: next_rd_data = phase_status_low;
                ADDR_RX_ALIGN_SIGNAL: next_rd_data = rx_align_signal;
                ADDR_RX_LINE_SIGNAL_STATUS: next_rd_data = rx_line_signal_status;
                ADDR_JITTER_BUFFER_STATUS: next_rd_data = jitter_buffer_status;
                ADDR_RX_NONALIGN_SIGNAL: next_rd_data = rx_nonalign_signal;
                ADDR_RX_MULTIFRAME_SIGNAL: next_rd_data = rx_multiframe_signal;
                ADDR_ALARM_STATUS_SECOND: next_rd_data = alarm_status_second;
                ADDR_PART_IDENTIFIER: next_rd_data = PART_ID;
                default: next_rd_data = UNUSED_READ; // [R1]
            endcase
        end
    end

    // Registered read data; reading touches no status state
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            rd_data <= RESET_BYTE;
            rd_data_oe_n <= 1'b1;
        end
        else
        begin
            rd_data <= next_rd_data; // [R12]
            rd_data_oe_n <= !(host_read && bus_state == BUS_ACTIVE);
        end
    end
endmodule
`default_nettype wire

// ### verif/esb_host_model.sv
// Host processor model for the parallel read port
`timescale 1ns/1ps
`default_nettype none
module esb_host_model
(
    // Clock
    input wire logic ref_clk,
    // Bus pins
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [4:0] addr,
    output logic [1:0] page,
    input wire logic [7:0] rd_data,
    input wire logic rd_data_oe_n
);
    initial {cs_n, rd_n, wr_n, addr, page} = 10'h3ff;
    // Read: hold strobes and address until drive enable is seen
    task automatic read(input logic [4:0] a, input logic [1:0] p, output logic [7:0] d,
        output bit ok);
        int n = 0;
        @(posedge ref_clk);
        #1;
        {cs_n, rd_n, addr, page} = {2'b00, a, p};
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while (rd_data_oe_n !== 1'b0 && n < 8);
        ok = (rd_data_oe_n === 1'b0);
        d = rd_data;
        {cs_n, rd_n, addr, page} = {2'b11, ~a, ~p}; // Released pins do not keep old value
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    // Write strobe on a read-only address
    task automatic write(input logic [4:0] a);
        @(posedge ref_clk);
        #1;
        {cs_n, wr_n, addr, page} = {2'b00, a, 2'h3};
        repeat (4) @(posedge ref_clk);
        #1;
        {cs_n, wr_n, addr, page} = {2'b11, ~a, 2'h0};
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ### verif/esb_status_bank_asserts.sv
// Concurrent checks on the sync status bank ports
`timescale 1ns/1ps
`default_nettype none
module esb_status_bank_asserts
    import esb_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h5a // Arbitrary value
)
(
    // Watched ports
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [4:0] addr,
    input wire logic [1:0] page,
    input wire logic [7:0] rd_data,
    input wire logic frame_loss,
    input wire logic multiframe_loss,
    input wire logic crc4_multiframe_loss,
    input wire logic crc4_interwork_state,
    input wire logic ebit_strobe,
    input wire logic maintenance_enable,
    input wire logic auto_interwork_enable,
    input wire logic frame_search_force
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Read data shows the address seen three edges back, once out of reset
    sequence sync_sel;
        !$past(reset, 3) && !$past(reset, 2) && !$past(reset) &&
            $past(addr, 3) == ADDR_FRAME_SYNC_STATUS && $past(page, 3) == PAGE_STATUS;
    endsequence
    sequence ident_sel;
        !$past(reset, 3) && !$past(reset, 2) && !$past(reset) &&
            $past(addr, 3) == ADDR_PART_IDENTIFIER && $past(page, 3) == PAGE_STATUS;
    endsequence
    // Live level bits of the sync status word
    a_frame_loss_bit: assert property (sync_sel |-> rd_data[7] == $past(frame_loss))
        else $error("frame loss bit wrong");
    a_mframe_loss_bit: assert property (sync_sel |-> rd_data[6] == $past(multiframe_loss))
        else $error("multiframe loss bit wrong");
    a_crc_loss_bit: assert property (sync_sel |-> rd_data[5] == $past(crc4_multiframe_loss))
        else $error("crc4 loss bit wrong");
    a_interwork_bit: assert property (sync_sel |-> rd_data[0] == $past(crc4_interwork_state))
        else $error("interwork bit wrong");
    // Latched E bits only move after a strobe
    a_ebit_hold: assert property ((sync_sel ##1 (sync_sel ##0 !$past(ebit_strobe, 2))) |->
        rd_data[4:3] == $past(rd_data[4:3])) else $error("e bits changed without strobe");
    a_alarm_clear: assert property ((sync_sel ##0 $past(frame_loss, 2) == 1'b0) |->
        !rd_data[1]) else $error("alarm not cleared");
    a_timeout_clear: assert property ((sync_sel ##0 $past(frame_loss, 2)) |->
        !rd_data[2]) else $error("timeout not cleared");
    // Address map
    a_unused_zero: assert property (($past(addr, 3) inside {5'h1a, 5'h1c, 5'h1d, 5'h1e} ||
        $past(page, 3) != PAGE_STATUS) |-> rd_data == UNUSED_READ)
        else $error("unused read not zero");
    a_ident_value: assert property (ident_sel |-> rd_data == PART_ID)
        else $error("identifier wrong");
    a_force_single: assert property (frame_search_force |=> !frame_search_force)
        else $error("reframe pulse too long");
    a_force_gated: assert property (frame_search_force |->
        $past(maintenance_enable, 3) && !$past(auto_interwork_enable, 3))
        else $error("reframe pulse without maintenance option");
endmodule
bind esb_status_bank esb_status_bank_asserts #(.PART_ID(PART_ID)) chk (.ref_clk, .reset, .addr,
    .page, .rd_data, .frame_loss, .multiframe_loss, .crc4_multiframe_loss, .crc4_interwork_state,
    .ebit_strobe, .maintenance_enable, .auto_interwork_enable, .frame_search_force);
`default_nettype wire

// ### verif/testbench.sv
// Self-checking testbench for the sync status bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import esb_pkg::*;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary value
    logic ref_clk = 1'b0, reset = 1'b1, cs_n, rd_n, wr_n, rd_data_oe_n, frame_search_force;
    logic [4:0] addr;
    logic [1:0] page;
    logic [7:0] rd_data, d, sw [10];
    logic frame_loss = 1'b1, multiframe_loss = 1'b1, crc4_multiframe_loss = 1'b1;
    logic ebit_strobe = 1'b0, rx_ebit_first = 1'b0, rx_ebit_second = 1'b0;
    logic crc4_interwork_state = 1'b0, maintenance_enable = 1'b0, auto_interwork_enable = 1'b0;
    int n_errors = 0, n_tests = 0, n_force = 0;
    esb_status_bank #(.CRC4_SEARCH_LIMIT(20), .PROLONGED_LOSS_LIMIT(50), .PART_ID(ID)) uut (
        .ref_clk, .reset, .cs_n, .rd_n, .wr_n, .addr, .page, .rd_data, .rd_data_oe_n,
        .frame_loss, .multiframe_loss, .crc4_multiframe_loss, .ebit_strobe, .rx_ebit_first,
        .rx_ebit_second, .crc4_interwork_state, .maintenance_enable, .auto_interwork_enable,
        .alarm_status_first(sw[0]), .timer_status(sw[1]), .phase_status_high(sw[2]),
        .phase_status_low(sw[3]), .rx_align_signal(sw[4]), .rx_line_signal_status(sw[5]),
        .jitter_buffer_status(sw[6]), .rx_nonalign_signal(sw[7]),
        .rx_multiframe_signal(sw[8]), .alarm_status_second(sw[9]), .frame_search_force);
    esb_host_model host (.ref_clk, .cs_n, .rd_n, .wr_n, .addr, .page, .rd_data, .rd_data_oe_n);
    // Clock and reframe pulse counter
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (frame_search_force === 1'b1) n_force++;
    task automatic print_verdict();
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [1:0] p = PAGE_STATUS);
        bit ok;
        host.read(a, p, d, ok);
        if (!ok)
        begin
            n_errors++;
            print_verdict();
        end
    endtask
    task automatic t_words();
        for (int i = 0; i < 10; i++)
        begin
            rd(5'(i + (i < 9 ? 17 : 18)));
            chk("status word", sw[i], d);
        end
        rd(ADDR_PART_IDENTIFIER);
        chk("identifier", ID, d);
        for (int a = 26; a < 31; a++)
        begin
            rd(5'(a), a == 27 ? 2'h2 : PAGE_STATUS);
            chk("unused", 8'h00, d);
        end
    endtask
    task automatic t_sync();
        logic [3:0] v;
        for (int k = 0; k < 16; k++)
        begin
            v = 4'(k);
            {frame_loss, multiframe_loss, crc4_multiframe_loss, crc4_interwork_state} = v;
            rd(ADDR_FRAME_SYNC_STATUS);
            chk("sync levels", {v[3:1], 4'h0, v[0]}, d & 8'he1);
        end
    endtask
    task automatic t_ebit(input logic [1:0] e);
        {rx_ebit_first, rx_ebit_second, ebit_strobe} = {e, 1'b1};
        @(posedge ref_clk) #1;
        {rx_ebit_first, rx_ebit_second, ebit_strobe} = {~e, 1'b0};
        rd(ADDR_FRAME_SYNC_STATUS);
        chk("e bits", {3'h0, e, 3'h0}, d & 8'h18);
    endtask
    task automatic t_crc(input logic m, input logic au, input int pulses);
        int base;
        {maintenance_enable, auto_interwork_enable} = {m, au};
        {frame_loss, crc4_multiframe_loss} = 2'b01;
        base = n_force;
        rd(ADDR_FRAME_SYNC_STATUS);
        chk("timeout early", 8'h00, d & 8'h04);
        repeat (30) @(posedge ref_clk) #1;
        rd(ADDR_FRAME_SYNC_STATUS);
        chk("timeout set", 8'h04, d & 8'h04);
        chk("reframe pulses", 8'(pulses), 8'(n_force - base));
        crc4_multiframe_loss = 1'b0;
        rd(ADDR_FRAME_SYNC_STATUS);
        chk("timeout clear", 8'h00, d & 8'h04);
    endtask
    task automatic t_alarm();
        {frame_loss, multiframe_loss, crc4_multiframe_loss, crc4_interwork_state} = 4'he;
        rd(ADDR_FRAME_SYNC_STATUS);
        chk("alarm early", 8'h00, d & 8'h02);
        repeat (60) @(posedge ref_clk) #1;
        rd(ADDR_FRAME_SYNC_STATUS);
        chk("alarm set", 8'h02, d & 8'h02);
        host.write(ADDR_FRAME_SYNC_STATUS);
        rd(ADDR_FRAME_SYNC_STATUS);
        chk("after write", 8'he2, d & 8'he3);
        frame_loss = 1'b0;
        rd(ADDR_FRAME_SYNC_STATUS);
        chk("alarm clear", 8'h00, d & 8'h02);
    endtask
    initial
    begin
        for (int i = 0; i < 10; i++)
            sw[i] = 8'(i * 37 + 90);
        repeat (16) @(posedge ref_clk) #1;
        reset = 1'b0;
        repeat (3) @(posedge ref_clk) #1;
        t_words();
        t_sync();
        t_ebit(2'b10);
        t_ebit(2'b01);
        t_crc(1'b1, 1'b0, 1);
        t_crc(1'b1, 1'b1, 0);
        t_crc(1'b0, 1'b0, 0);
        t_alarm();
        print_verdict();
    end
endmodule
`default_nettype wire
